// File: fsr_pkg.sv
// package: constants, opcodes, register map and states of the security-register flash host
package fsr_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned SYS_PERIOD_NS = 8;
  localparam int unsigned SCK_PERIOD_NS = 64;
  localparam int unsigned CS_HIGH_NS    = 50;
  // half a serial clock period, rounded down so the link never runs slower than intended
  localparam logic [2:0]  SCK_HALF_CYC  = 3'(SCK_PERIOD_NS / (2 * SYS_PERIOD_NS));
  // least chip-select high time, rounded up
  localparam logic [3:0]  CS_HIGH_CYC   = 4'((CS_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  // ==========================================================================
  // flash opcodes
  localparam logic [7:0] OPC_ID_READ   = 8'h9F;
  localparam logic [7:0] OPC_PTAB_READ = 8'h5A;
  localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
  localparam logic [7:0] OPC_SEC_PROG  = 8'h42;
  localparam logic [7:0] OPC_SEC_READ  = 8'h48;
  localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
  localparam logic [7:0] OPC_STAT_READ = 8'h05;

  // ==========================================================================
  // operation codes written by software
  localparam logic [2:0] OP_ID_READ   = 3'h0;
  localparam logic [2:0] OP_PTAB_READ = 3'h1;
  localparam logic [2:0] OP_SEC_ERASE = 3'h2;
  localparam logic [2:0] OP_SEC_PROG  = 3'h3;
  localparam logic [2:0] OP_SEC_READ  = 3'h4;

  // ==========================================================================
  // register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_LEN    = 8'h08;
  localparam logic [7:0] REG_TXDATA = 8'h0C;
  localparam logic [7:0] REG_RXDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  localparam int unsigned CTRL_OP_LSB    = 0;
  localparam int unsigned CTRL_A4_BIT    = 3;
  localparam int unsigned CTRL_QM_BIT    = 4;
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned ADDR_SEL_LSB   = 8;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;
  localparam int unsigned STAT_ERR_BIT   = 2;
  localparam int unsigned STAT_RV_BIT    = 3;
  localparam int unsigned STAT_WREQ_BIT  = 4;
  localparam int unsigned STAT_BYTE_LSB  = 8;
  localparam logic [8:0]  LEN_MAX        = 9'h100;
  localparam int unsigned FLASH_BUSY_BIT = 0;

  // ==========================================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WREN,
    ST_GAP,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_TX,
    ST_RX,
    ST_PCMD,
    ST_PRX
  } fsr_st_e;

endpackage : fsr_pkg

// File: fsr_host.sv
// module: host sequencer for identification, parameter-table and security-register operations
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ns
// ============================================================================
// Behaviour
// - table read: opcode 5Ah, 24-bit address, eight dummy clocks, then data.
// - table address bits 23..8 are zero; low byte selects start byte.
// - table read always uses 24-bit address, single-line mode only.
// - security erase 44h needs write enable issued beforehand.
// - register select in address bits 15..12 as 1..3, offset in 7..0.
// - chip select rises right after last address bit of an erase.
// - program 42h takes 1 to 256 bytes, needs write enable first.
// - chip select stays low through opcode, address and all data bytes.
// - security read: 48h, address, eight dummy clocks; device samples on rise.
// - security ops single-line only, 32-bit address in four-byte mode.
module fsr_host (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  output logic             o_cs_n,
  output logic             o_sck,
  output logic [3:0]       o_io_out,
  output logic [3:0]       o_io_oe,
  input  wire logic [3:0]  i_io_in
);

  typedef struct packed {
    fsr_pkg::fsr_st_e st;
    fsr_pkg::fsr_st_e gap_nx;
    logic [2:0]       cnt;
    logic             ph;
    logic [3:0]       gcnt;
    logic             sck;
    logic             cs_n;
    logic [3:0]       io_out;
    logic [3:0]       io_oe;
    logic [3:0]       sy1;
    logic [3:0]       sy2;
    logic [31:0]      sh;
    logic [5:0]       nb;
    logic [7:0]       rx;
    logic [8:0]       left;
    logic [2:0]       op;
    logic             a4;
    logic             qm;
    logic [7:0]       off;
    logic [1:0]       sel;
    logic [8:0]       len;
    logic [7:0]       wdat;
    logic             wv;
    logic [7:0]       rdat;
    logic             rv;
    logic             busy;
    logic             done;
    logic             err;
    logic [7:0]       stat;
    logic             ack;
    logic [31:0]      dat;
  } fsr_state_s;

  fsr_state_s q;
  fsr_state_s d;
  logic       wb_hit;
  logic       start;
  logic       bad;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] f_out(input logic [31:0] sh, input logic qm);
    f_out = qm ? sh[31:28] : {3'h0, sh[31]};
  endfunction : f_out

  function automatic logic [7:0] f_opc(input logic [2:0] op);
    case (op)
      fsr_pkg::OP_PTAB_READ: f_opc = fsr_pkg::OPC_PTAB_READ;
      fsr_pkg::OP_SEC_ERASE: f_opc = fsr_pkg::OPC_SEC_ERASE;
      fsr_pkg::OP_SEC_PROG:  f_opc = fsr_pkg::OPC_SEC_PROG;
      fsr_pkg::OP_SEC_READ:  f_opc = fsr_pkg::OPC_SEC_READ;
      default:               f_opc = fsr_pkg::OPC_ID_READ;
    endcase
  endfunction : f_opc

  // address left-aligned in the shifter; table reads stay 24-bit in any address mode
  function automatic logic [31:0] f_addr(input logic [2:0] op, input logic a4,
                                         input logic [1:0] sel, input logic [7:0] off);
    if (op == fsr_pkg::OP_PTAB_READ)
      f_addr = {16'h0000, off, 8'h00};
    else if (a4)
      f_addr = {16'h0000, 2'b00, sel, 4'h0, off};
    else
      f_addr = {8'h00, 2'b00, sel, 4'h0, off, 8'h00};
  endfunction : f_addr

  function automatic logic f_is_sec(input logic [2:0] op);
    f_is_sec = (op == fsr_pkg::OP_SEC_ERASE) || (op == fsr_pkg::OP_SEC_PROG)
            || (op == fsr_pkg::OP_SEC_READ);
  endfunction : f_is_sec

  // ==========================================================================
  // next state
  always_comb
  begin
    d      = q;
    d.sy1  = i_io_in;
    d.sy2  = q.sy1;
    d.ack  = 1'b0;
    wb_hit = i_wb_cyc & i_wb_stb & ~q.ack;
    start  = 1'b0;
    bad    = 1'b0;

    // serial clock divider: outputs change only while the clock is low
    if (q.st != fsr_pkg::ST_IDLE && q.st != fsr_pkg::ST_GAP && q.nb != 6'h00)
    begin
      if (q.cnt != fsr_pkg::SCK_HALF_CYC - 3'h1)
        d.cnt = q.cnt + 3'h1;
      else
      begin
        d.cnt = 3'h0;
        if (!q.ph)
        begin
          d.sck = 1'b1;
          d.ph  = 1'b1;
          d.rx  = q.qm ? {q.rx[3:0], q.sy2} : {q.rx[6:0], q.sy2[1]};
        end
        else
        begin
          d.sck    = 1'b0;
          d.ph     = 1'b0;
          d.nb     = q.nb - 6'h01;
          d.sh     = q.qm ? {q.sh[27:0], 4'h0} : {q.sh[30:0], 1'b0};
          d.io_out = f_out(d.sh, q.qm);
          if (q.nb == 6'h01 && q.st == fsr_pkg::ST_RX)
          begin
            d.rdat = q.rx;
            d.rv   = 1'b1;
            d.left = q.left - 9'h001;
          end
        end
      end
    end
    else
    begin
      case (q.st)
        fsr_pkg::ST_WREN:
        begin
          d.cs_n   = 1'b1;
          d.st     = fsr_pkg::ST_GAP;
          d.gap_nx = fsr_pkg::ST_CMD;
          d.gcnt   = 4'h0;
        end
        fsr_pkg::ST_GAP:
        begin
          if (q.gcnt != fsr_pkg::CS_HIGH_CYC - 4'h1)
            d.gcnt = q.gcnt + 4'h1;
          else
          begin
            d.cs_n = 1'b0;
            d.st   = q.gap_nx;
            if (q.gap_nx == fsr_pkg::ST_CMD)
              d.sh = {f_opc(q.op), 24'h000000};
            else
              d.sh = {fsr_pkg::OPC_STAT_READ, 24'h000000};
            d.nb     = 6'h08;
            d.io_out = f_out(d.sh, 1'b0);
          end
        end
        fsr_pkg::ST_CMD:
        begin
          if (q.op == fsr_pkg::OP_ID_READ)
          begin
            d.st     = fsr_pkg::ST_RX;
            d.io_oe  = q.qm ? 4'h0 : 4'h1;
            d.io_out = 4'h0;
          end
          else
          begin
            d.st     = fsr_pkg::ST_ADDR;
            d.sh     = f_addr(q.op, q.a4, q.sel, q.off);
            d.nb     = (q.op != fsr_pkg::OP_PTAB_READ && q.a4) ? 6'h20 : 6'h18;
            d.io_out = f_out(d.sh, 1'b0);
          end
        end
        fsr_pkg::ST_ADDR:
        begin
          if (q.op == fsr_pkg::OP_SEC_ERASE)
          begin
            d.cs_n   = 1'b1;
            d.st     = fsr_pkg::ST_GAP;
            d.gap_nx = fsr_pkg::ST_PCMD;
            d.gcnt   = 4'h0;
          end
          else if (q.op == fsr_pkg::OP_SEC_PROG)
            d.st = fsr_pkg::ST_TX;
          else
          begin
            d.st     = fsr_pkg::ST_DUMMY;
            d.sh     = 32'h00000000;
            d.nb     = 6'h08;
            d.io_out = 4'h0;
          end
        end
        fsr_pkg::ST_DUMMY:
          d.st = fsr_pkg::ST_RX;
        fsr_pkg::ST_TX:
        begin
          if (q.left == 9'h000)
          begin
            d.cs_n   = 1'b1;
            d.st     = fsr_pkg::ST_GAP;
            d.gap_nx = fsr_pkg::ST_PCMD;
            d.gcnt   = 4'h0;
          end
          else if (q.wv)
          begin
            // the link idles with chip select low until software supplies the byte
            d.sh     = {q.wdat, 24'h000000};
            d.nb     = 6'h08;
            d.wv     = 1'b0;
            d.left   = q.left - 9'h001;
            d.io_out = f_out(d.sh, 1'b0);
          end
        end
        fsr_pkg::ST_RX:
        begin
          if (q.left == 9'h000)
          begin
            d.cs_n   = 1'b1;
            d.st     = fsr_pkg::ST_IDLE;
            d.busy   = 1'b0;
            d.done   = 1'b1;
            d.io_oe  = 4'h0;
            d.io_out = 4'h0;
          end
          else if (!q.rv)
            d.nb = q.qm ? 6'h02 : 6'h08;
        end
        fsr_pkg::ST_PCMD:
        begin
          d.st = fsr_pkg::ST_PRX;
          d.nb = 6'h08;
        end
        fsr_pkg::ST_PRX:
        begin
          d.stat = q.rx;
          d.cs_n = 1'b1;
          if (q.rx[fsr_pkg::FLASH_BUSY_BIT])
          begin
            d.st     = fsr_pkg::ST_GAP;
            d.gap_nx = fsr_pkg::ST_PCMD;
            d.gcnt   = 4'h0;
          end
          else
          begin
            d.st     = fsr_pkg::ST_IDLE;
            d.busy   = 1'b0;
            d.done   = 1'b1;
            d.io_oe  = 4'h0;
            d.io_out = 4'h0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // wishbone slave: one ack per request, dropped in the following cycle
    if (wb_hit)
    begin
      d.ack = 1'b1;
      d.dat = 32'h00000000;
      if (i_wb_adr == fsr_pkg::REG_CTRL)
      begin
        if (i_wb_we && !q.busy && i_wb_sel[0])
        begin
          d.op = i_wb_dat[fsr_pkg::CTRL_OP_LSB +: 3];
          d.a4 = i_wb_dat[fsr_pkg::CTRL_A4_BIT];
          d.qm = i_wb_dat[fsr_pkg::CTRL_QM_BIT];
        end
        start = i_wb_we & i_wb_sel[1] & i_wb_dat[fsr_pkg::CTRL_START_BIT];
        d.dat[fsr_pkg::CTRL_OP_LSB +: 3] = q.op;
        d.dat[fsr_pkg::CTRL_A4_BIT]      = q.a4;
        d.dat[fsr_pkg::CTRL_QM_BIT]      = q.qm;
      end
      else if (i_wb_adr == fsr_pkg::REG_ADDR)
      begin
        if (i_wb_we && !q.busy && i_wb_sel[0])
          d.off = i_wb_dat[7:0];
        if (i_wb_we && !q.busy && i_wb_sel[1])
          d.sel = i_wb_dat[fsr_pkg::ADDR_SEL_LSB +: 2];
        d.dat[7:0]                         = q.off;
        d.dat[fsr_pkg::ADDR_SEL_LSB +: 2] = q.sel;
      end
      else if (i_wb_adr == fsr_pkg::REG_LEN)
      begin
        if (i_wb_we && !q.busy && i_wb_sel[0])
          d.len[7:0] = i_wb_dat[7:0];
        if (i_wb_we && !q.busy && i_wb_sel[1])
          d.len[8] = i_wb_dat[8];
        d.dat[8:0] = q.len;
      end
      else if (i_wb_adr == fsr_pkg::REG_TXDATA)
      begin
        // a write while a byte is still pending overwrites it
        if (i_wb_we && i_wb_sel[0])
        begin
          d.wdat = i_wb_dat[7:0];
          d.wv   = 1'b1;
        end
        d.dat[7:0] = q.wdat;
      end
      else if (i_wb_adr == fsr_pkg::REG_RXDATA)
      begin
        // the engine only sets this flag while it is clear, so a read never hides a new byte
        if (!i_wb_we && q.rv)
          d.rv = 1'b0;
        d.dat[7:0] = q.rdat;
      end
      else if (i_wb_adr == fsr_pkg::REG_STATUS)
      begin
        d.dat[fsr_pkg::STAT_BUSY_BIT]     = q.busy;
        d.dat[fsr_pkg::STAT_DONE_BIT]     = q.done;
        d.dat[fsr_pkg::STAT_ERR_BIT]      = q.err;
        d.dat[fsr_pkg::STAT_RV_BIT]       = q.rv;
        d.dat[fsr_pkg::STAT_WREQ_BIT]     = (q.st == fsr_pkg::ST_TX) && !q.wv
                                          && (q.left != 9'h000);
        d.dat[fsr_pkg::STAT_BYTE_LSB +: 8] = q.stat;
      end
    end

    // start: refused while busy; bad combinations only clear done and raise the error flag
    if (start && q.st == fsr_pkg::ST_IDLE)
    begin
      bad = (d.qm && d.op != fsr_pkg::OP_ID_READ)
         || (f_is_sec(d.op) && d.sel == 2'b00)
         || (d.op == fsr_pkg::OP_SEC_PROG && (d.len == 9'h000 || d.len > fsr_pkg::LEN_MAX))
         || (d.op > fsr_pkg::OP_SEC_READ);
      d.done = 1'b0;
      d.err  = bad;
      if (!bad)
      begin
        d.busy  = 1'b1;
        d.left  = d.len;
        d.rv    = 1'b0;
        d.wv    = 1'b0;
        d.cs_n  = 1'b0;
        d.cnt   = 3'h0;
        d.ph    = 1'b0;
        d.io_oe = d.qm ? 4'hF : 4'h1;
        if (d.op == fsr_pkg::OP_SEC_ERASE || d.op == fsr_pkg::OP_SEC_PROG)
        begin
          d.st = fsr_pkg::ST_WREN;
          d.sh = {fsr_pkg::OPC_WR_ENABLE, 24'h000000};
          d.nb = 6'h08;
        end
        else
        begin
          d.st = fsr_pkg::ST_CMD;
          d.sh = {f_opc(d.op), 24'h000000};
          d.nb = d.qm ? 6'h02 : 6'h08;
        end
        d.io_out = f_out(d.sh, d.qm);
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      q      <= '0;
      q.cs_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign o_wb_ack = q.ack;
  assign o_wb_dat = q.dat;
  assign o_cs_n   = q.cs_n;
  assign o_sck    = q.sck;
  assign o_io_out = q.io_out;
  assign o_io_oe  = q.io_oe;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  a_erase_cs_rise: assert property ((q.st == fsr_pkg::ST_ADDR && q.op == fsr_pkg::OP_SEC_ERASE
    && q.nb == 6'h01 && q.ph && q.cnt == fsr_pkg::SCK_HALF_CYC - 3'h1) |=> ##1 o_cs_n)
    else $error("erase frame not closed right after last address bit");
  a_wren_first: assert property ((q.st == fsr_pkg::ST_IDLE && start && !bad
    && (d.op == fsr_pkg::OP_SEC_ERASE || d.op == fsr_pkg::OP_SEC_PROG))
    |=> q.st == fsr_pkg::ST_WREN && q.sh[31:24] == fsr_pkg::OPC_WR_ENABLE)
    else $error("erase or program not preceded by write enable");
  a_ptab_addr: assert property ($rose(q.st == fsr_pkg::ST_ADDR) && q.op == fsr_pkg::OP_PTAB_READ
    |-> q.nb == 6'h18 && q.sh[31:16] == 16'h0000)
    else $error("table read address not 24-bit with zero upper bits");
  a_sec_addr: assert property ($rose(q.st == fsr_pkg::ST_ADDR) && f_is_sec(q.op)
    |-> q.nb == (q.a4 ? 6'h20 : 6'h18) && q.sel != 2'b00)
    else $error("security address width or select wrong");
  a_dummy_len: assert property ($rose(q.st == fsr_pkg::ST_DUMMY) |-> q.nb == 6'h08)
    else $error("dummy phase not eight clocks");
  a_tx_cs_low: assert property (q.st == fsr_pkg::ST_TX |-> !o_cs_n)
    else $error("chip select high during program data");
  a_out_on_low: assert property ($changed(o_io_out) |-> !o_sck)
    else $error("data changed while serial clock high");
  a_quad_cmd: assert property (q.st == fsr_pkg::ST_CMD && q.qm
    |-> o_io_oe == 4'hF && q.op == fsr_pkg::OP_ID_READ)
    else $error("four-wire mode used for wrong op");
  a_poll_done: assert property ($rose(q.done) && (q.op == fsr_pkg::OP_SEC_ERASE
    || q.op == fsr_pkg::OP_SEC_PROG) |-> !q.stat[fsr_pkg::FLASH_BUSY_BIT])
    else $error("write op finished while flash busy");
  a_rx_byte: assert property ((q.st == fsr_pkg::ST_RX && q.nb == 6'h01 && q.ph
    && q.cnt == fsr_pkg::SCK_HALF_CYC - 3'h1) |=> q.rv && q.rdat == $past(q.rx))
    else $error("received byte not delivered");

  c_id_read:  cover property ($rose(q.done) && q.op == fsr_pkg::OP_ID_READ);
  c_ptab:     cover property ($rose(q.done) && q.op == fsr_pkg::OP_PTAB_READ);
  c_erase:    cover property ($rose(q.done) && q.op == fsr_pkg::OP_SEC_ERASE);
  c_prog:     cover property ($rose(q.done) && q.op == fsr_pkg::OP_SEC_PROG);

endmodule : fsr_host

// File: fsr_flash_model.sv
// device model: serial flash with id, parameter table and three security registers
`timescale 1ns/1ns
module fsr_flash_model #(
  parameter logic [7:0] MAN_ID     = 8'h3C, // arbitrary value
  parameter logic [7:0] MEM_TYPE   = 8'h40,
  parameter logic [7:0] CAPACITY   = 8'h19,
  parameter int         BUSY_POLLS = 3
) (
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic [3:0] i_io,
  input  wire logic       i_a4,
  input  wire logic       i_qm,
  input  wire logic [2:0] i_lock,
  output logic [3:0]      o_io,
  output int              o_faults
);
  logic [7:0]  sec [1:3][0:255];
  logic [7:0]  opc, cur, ob;
  logic [31:0] adr;
  logic [7:0]  pq[$];
  logic [1:0]  s;
  int          bits, busy, alen, ds, k;
  logic        write_enable_latch;

  function automatic logic [7:0] byte_at(input int j);
    case (opc)
      8'h9F: return (j % 3 == 0) ? MAN_ID : (j % 3 == 1) ? MEM_TYPE : CAPACITY;
      8'h5A: return 8'(adr[7:0] + j) ^ 8'hA6;
      8'h48: return sec[s][8'(adr[7:0] + j)];
      8'h05: return {7'h0, busy != 0};
      default: return 8'hFF;
    endcase
  endfunction : byte_at

  initial
  begin
    o_io = 4'h0; o_faults = 0; busy = 0; write_enable_latch = 0; bits = 0;
    for (int r = 1; r <= 3; r++)
      for (int i = 0; i < 256; i++)
        sec[r][i] = 8'(i * 3 + r);
  end

  always_comb alen = (opc == 8'h5A || !i_a4) ? 24 : 32;
  always_comb s = adr[13:12];
  always_comb ds = (opc == 8'h9F || opc == 8'h05) ? 8 : 16 + alen;

  always @(negedge i_cs_n)
  begin
    bits = 0; opc = 0; adr = 0; pq.delete();
  end

  // =========================================================================
  // input shifting on rising clock
  always @(posedge i_sck)
  if (!i_cs_n)
  begin
    if (bits < 8)
      opc = i_qm ? {opc[3:0], i_io} : {opc[6:0], i_io[0]};
    else if (bits < 8 + alen)
      adr = {adr[30:0], i_io[0]};
    else if (opc == 8'h42)
    begin
      cur = {cur[6:0], i_io[0]};
      if ((bits - 8 - alen) % 8 == 7) pq.push_back(cur);
    end
    bits += i_qm ? 4 : 1;
    if (bits == 8 && i_qm && opc != 8'h9F) o_faults++;
  end

  // =========================================================================
  // output on falling clock, msb first
  always @(negedge i_sck)
  if (!i_cs_n && bits >= ds)
  begin
    k = bits - ds;
    if (k % 8 == 0) ob = byte_at(k / 8);
    if (i_qm) o_io = (k % 8 == 0) ? ob[7:4] : ob[3:0];
    else o_io[1] = ob[7 - k % 8];
  end

  // =========================================================================
  // actions when chip select rises
  always @(posedge i_cs_n)
  begin
    o_io = ~o_io;
    if (opc == 8'h06) write_enable_latch = 1;
    if (opc == 8'h05 && busy > 0)
    begin
      busy--;
      if (busy == 0) write_enable_latch = 0;
    end
    if (opc == 8'h5A && adr[23:8] != 0) o_faults++;
    if ((opc == 8'h44 || opc == 8'h42 || opc == 8'h48) &&
        (adr[31:16] != 0 || adr[11:8] != 0 || adr[15:14] != 0 || s == 0))
      o_faults++;
    if (opc == 8'h44)
    begin
      if (bits != 8 + alen) o_faults++;
      else if (write_enable_latch && busy == 0 && !i_lock[s - 1])
      begin
        for (int i = 0; i < 256; i++) sec[s][i] = 8'hFF;
        busy = BUSY_POLLS;
      end
    end
    if (opc == 8'h42)
    begin
      if (pq.size() == 0 || (bits - 8 - alen) % 8 != 0) o_faults++;
      else if (write_enable_latch && busy == 0 && !i_lock[s - 1])
      begin
        foreach (pq[i]) sec[s][8'(adr[7:0] + i)] &= pq[i];
        busy = BUSY_POLLS;
      end
    end
  end
endmodule : fsr_flash_model

// File: tb_fsr_host.sv
// testbench: self-checking run of the security-register flash host against a device model
`timescale 1ns/1ns
module tb_fsr_host;
  localparam logic [7:0] MAN = 8'h3C; // arbitrary value
  logic        i_clk_sys, i_nrst, cyc, stb, we, ack, cs_n, sck, a4, qm;
  logic [7:0]  adr, off;
  logic [3:0]  sel, h_out, h_oe, m_io, io_in;
  logic [31:0] wdat, rdat, st, v, seed;
  logic [2:0]  lock;
  int          faults, mismatches, samples_checked;
  logic [7:0]  rxq[$], eq[$], txq[$];
  logic [7:0]  bm [1:3][0:255];

  assign io_in = (h_oe & h_out) | (~h_oe & m_io);

  fsr_host DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack),
    .o_wb_dat(rdat), .o_cs_n(cs_n), .o_sck(sck), .o_io_out(h_out), .o_io_oe(h_oe),
    .i_io_in(io_in));
  fsr_flash_model #(.MAN_ID(MAN)) FM (.i_cs_n(cs_n), .i_sck(sck), .i_io(io_in), .i_a4(a4),
    .i_qm(qm), .i_lock(lock), .o_io(m_io), .o_faults(faults));

  initial
  begin
    i_clk_sys = 0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // =========================================================================
  // wishbone classic single cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge i_clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do @(posedge i_clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask : wb

  task automatic poll(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    q = 0;
    while (q[b] !== 1'b1 && n < 5000)
    begin
      wb(0, fsr_pkg::REG_STATUS, 0, q);
      n++;
    end
    chk("status wait", 32'(q[b]), 1);
  endtask : poll

  task automatic run_op(input logic [2:0] op, input logic ma, input logic mq,
                        input logic [1:0] s, input logic [7:0] o, input int len, input bit err);
    logic [31:0] q;
    a4 <= ma; qm <= mq; rxq = {};
    wb(1, fsr_pkg::REG_ADDR, {22'h0, s, o}, q);
    wb(1, fsr_pkg::REG_LEN, 32'(len), q);
    wb(1, fsr_pkg::REG_CTRL, {23'h0, 1'b1, 3'h0, mq, ma, op}, q);
    if (err) poll(fsr_pkg::STAT_ERR_BIT);
    else
    begin
      for (int i = 0; i < len && op != fsr_pkg::OP_SEC_ERASE; i++)
        if (op == fsr_pkg::OP_SEC_PROG)
        begin
          poll(fsr_pkg::STAT_WREQ_BIT);
          wb(1, fsr_pkg::REG_TXDATA, {24'h0, txq[i]}, q);
        end
        else
        begin
          poll(fsr_pkg::STAT_RV_BIT);
          wb(0, fsr_pkg::REG_RXDATA, 0, q);
          rxq.push_back(q[7:0]);
        end
      poll(fsr_pkg::STAT_DONE_BIT);
    end
    wb(0, fsr_pkg::REG_STATUS, 0, st);
  endtask : run_op

  task automatic cmp_rx(input string what);
    chk(what, 32'(rxq.size()), 32'(eq.size()));
    foreach (eq[i]) chk(what, 32'(rxq[i]), 32'(eq[i]));
  endtask : cmp_rx

  initial
  begin
    #400000;
    mismatches++;
    test_done();
  end

  initial
  begin
    i_nrst = 0; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
    a4 = 0; qm = 0; lock = 3'h4; seed = 32'h0000_0007;
    for (int r = 1; r <= 3; r++)
      for (int i = 0; i < 256; i++)
        bm[r][i] = 8'(i * 3 + r);
    repeat (5) @(posedge i_clk_sys);
    i_nrst <= 1;
    @(posedge i_clk_sys);
    chk("cs idle", 32'(cs_n), 1);
    for (int m = 0; m < 2; m++)
    begin
      run_op(fsr_pkg::OP_ID_READ, 0, m[0], 0, 0, 3, 0);
      eq = {MAN, 8'h40, 8'h19};
      cmp_rx("id bytes");
    end
    $display("test id done");
    for (int m = 0; m < 2; m++)
    begin
      v = xs();
      off = v[7:0];
      run_op(fsr_pkg::OP_PTAB_READ, m[0], 0, 0, off, 4, 0);
      eq = {};
      for (int i = 0; i < 4; i++) eq.push_back(8'(off + i) ^ 8'hA6);
      cmp_rx("table bytes");
    end
    run_op(fsr_pkg::OP_PTAB_READ, 0, 1, 0, 0, 1, 1);
    chk("table four-wire refused", 32'(st[fsr_pkg::STAT_ERR_BIT]), 1);
    run_op(fsr_pkg::OP_SEC_ERASE, 0, 0, 0, 0, 1, 1);
    chk("select zero refused", 32'(st[fsr_pkg::STAT_ERR_BIT]), 1);
    $display("test table done");
    for (int r = 1; r <= 3; r++)
    begin
      v = xs();
      off = v[7:0];
      run_op(fsr_pkg::OP_SEC_ERASE, r[0], 0, r[1:0], off, 1, 0);
      chk("erase busy end", 32'(FM.busy), 0);
      chk("latch after erase", 32'(FM.write_enable_latch), 32'(r == 3));
      if (r != 3)
        for (int i = 0; i < 256; i++) bm[r][i] = 8'hFF;
      txq = {};
      for (int i = 0; i < 3; i++)
      begin
        v = xs();
        txq.push_back(v[7:0]);
        if (r != 3) bm[r][8'(off + i)] &= v[7:0];
      end
      run_op(fsr_pkg::OP_SEC_PROG, r[0], 0, r[1:0], off, 3, 0);
      chk("latch after program", 32'(FM.write_enable_latch), 32'(r == 3));
      run_op(fsr_pkg::OP_SEC_READ, ~r[0], 0, r[1:0], 8'(off - 1), 5, 0);
      eq = {};
      for (int i = 0; i < 5; i++) eq.push_back(bm[r][8'(off - 1 + i)]);
      cmp_rx("security bytes");
    end
    run_op(fsr_pkg::OP_SEC_READ, 0, 0, 2'd1, 8'hFE, 3, 0);
    eq = {bm[1][254], bm[1][255], bm[1][0]};
    cmp_rx("offset wrap");
    $display("test security done");
    wb(1, 8'h20, 32'hFFFF_FFFF, v);
    wb(0, 8'h20, 0, v);
    chk("unmapped read", v, 0);
    chk("link faults", 32'(faults), 0);
    $display("test bus done");
    test_done();
  end
endmodule : tb_fsr_host
